// ==== igu_pkg.sv ====
package igu_pkg;

  // gain code: 6 bits, code 0 = -12 dB, +0.75 dB per step, 63 = +35.25 dB
  localparam int unsigned GAIN_W        = 6;
  localparam logic [5:0]  GAIN_MIN_CODE = 6'h00;
  localparam logic [5:0]  GAIN_MAX_CODE = 6'h3f;
  localparam logic [5:0]  GAIN_RST      = 6'h10; // 0 dB after reset

  // gain control word layout (9 bits per channel)
  localparam int unsigned CTRL_W        = 9;
  localparam int unsigned GAIN_LSB      = 0;
  localparam int unsigned UNMUTE_BIT    = 6;
  localparam int unsigned ZC_EN_BIT     = 7;
  localparam int unsigned UPDATE_BIT    = 8;
  localparam logic        UNMUTE_RST    = 1'b1;
  localparam logic        ZC_EN_RST     = 1'b0;

  // timeout window in slow timer periods: force after 3 ticks,
  // which falls between 2 and 3 periods of the pending start
  localparam logic [1:0]  TMO_TICKS     = 2'h3;

  // per channel input select bits
  localparam int unsigned SEL_POS_BIT   = 0;
  localparam int unsigned SEL_NEG_BIT   = 1;
  localparam int unsigned SEL_LINE_BIT  = 2;

  localparam int unsigned NUM_CH        = 2;
  localparam int unsigned CH_LEFT       = 0;
  localparam int unsigned CH_RIGHT      = 1;

  typedef enum logic [1:0] {IGU_IDLE, IGU_WAIT_ZC} igu_ch_state_t;

endpackage : igu_pkg

// ==== igu_apply_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***********************************************************************
// per channel gate: decides when a requested gain change takes effect
// ***********************************************************************
module igu_apply_gate
  import igu_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_zc_en,
  input  wire logic i_zero_cross,
  input  wire logic i_tmo_en,
  input  wire logic i_slow_tick,
  output logic      o_apply,
  output logic      o_waiting
);

  igu_ch_state_t state_q;
  logic [1:0]    tick_cnt_q;
  logic          timed_out;

  assign timed_out = i_tmo_en && i_slow_tick && (tick_cnt_q == TMO_TICKS - 2'h1);

  // apply at once without zero-cross gating, else at crossing or timeout
  always_comb begin
    o_apply = 1'b0;
    unique case (state_q)
      IGU_IDLE:    o_apply = i_req && !i_zc_en;
      IGU_WAIT_ZC: o_apply = i_zero_cross || timed_out || !i_zc_en;
      default:     o_apply = 1'b0;
    endcase
  end
  assign o_waiting = (state_q == IGU_WAIT_ZC);

  // wait state, a fresh request while waiting simply keeps waiting
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= IGU_IDLE;
    end else if (state_q == IGU_IDLE) begin
      if (i_req && i_zc_en) begin
        state_q <= IGU_WAIT_ZC;
      end
    end else if (o_apply && !i_req) begin
      state_q <= IGU_IDLE;
    end
  end

  // slow tick counter, restarts on each new wait; counts only pulses
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || state_q == IGU_IDLE || i_req) begin
      tick_cnt_q <= 2'h0;
    end else if (i_slow_tick && i_tmo_en) begin
      tick_cnt_q <= tick_cnt_q + 2'h1;
    end
  end

endmodule : igu_apply_gate
`default_nettype wire

// ==== igu_input_gain_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - gain spans -12 to +35.25 dB, 0.75 steps
// - per channel gain, mute, update, zero-cross word
// - update bit acts on write, never stored
// - write without update stays pending only
// - update write applies both channels' pending gains
// - zero-cross enable delays change until crossing
// - zero-cross disabled applies change immediately
// - timeout forces pending change after ticks
// - level control acts as another gain writer
// - positive select: pin to amp or tie-off
// - negative select: pin to amp or tie-off
// - three sources: positive, negative, line input
// - path passes only with mix/boost powered
// - mute active when control bit 6 clear
module igu_input_gain_ctrl
  import igu_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // software writes, one strobe per channel
  input  wire logic [1:0]        i_gain_ctrl_wr,
  input  wire logic [CTRL_W-1:0] i_left_gain_ctrl,
  input  wire logic [CTRL_W-1:0] i_right_gain_ctrl,
  // level control writer, one strobe per channel
  input  wire logic [1:0]        i_auto_level_control_en,
  input  wire logic [1:0]        i_auto_level_wr,
  input  wire logic [GAIN_W-1:0] i_left_auto_gain,
  input  wire logic [GAIN_W-1:0] i_right_auto_gain,
  // zero crossing and timeout
  input  wire logic [1:0]        i_zero_cross,
  input  wire logic              i_zero_cross_timeout_ctrl,
  input  wire logic              i_slow_tick,
  // input select and power
  input  wire logic [2:0]        i_left_amp_input_select,
  input  wire logic [2:0]        i_right_amp_input_select,
  input  wire logic [1:0]        i_amp_power,
  input  wire logic [1:0]        i_mix_boost_power,
  // readback and analog controls
  output logic [CTRL_W-1:0]      o_left_gain_ctrl_rd,
  output logic [CTRL_W-1:0]      o_right_gain_ctrl_rd,
  output logic [GAIN_W-1:0]      o_left_active_gain,
  output logic [GAIN_W-1:0]      o_right_active_gain,
  output logic [1:0]             o_mute,
  output logic [1:0]             o_change_waiting,
  output logic [1:0]             o_mic_pos_in_sw,
  output logic [1:0]             o_mic_neg_in_sw,
  output logic [1:0]             o_line_level_in_sw,
  output logic [1:0]             o_mic_pos_in_tie,
  output logic [1:0]             o_mic_neg_in_tie,
  output logic [1:0]             o_amp_path_en
);

  // ***********************************************************************
  // per channel storage
  // ***********************************************************************
  logic [GAIN_W-1:0] pend_q   [NUM_CH];
  logic [GAIN_W-1:0] active_q [NUM_CH];
  logic [1:0]        unmute_q;
  logic [1:0]        zc_en_q;
  logic [1:0]        upd_strobe;
  logic [1:0]        apply;
  logic [CTRL_W-1:0] wr_word  [NUM_CH];
  logic [GAIN_W-1:0] auto_g   [NUM_CH];
  logic [2:0]        sel      [NUM_CH];

  assign wr_word[CH_LEFT]  = i_left_gain_ctrl;
  assign wr_word[CH_RIGHT] = i_right_gain_ctrl;
  assign auto_g[CH_LEFT]   = i_left_auto_gain;
  assign auto_g[CH_RIGHT]  = i_right_auto_gain;
  assign sel[CH_LEFT]      = i_left_amp_input_select;
  assign sel[CH_RIGHT]     = i_right_amp_input_select;

  // update bit is a write-time strobe only; either channel's update
  // write releases both channels' pending gains together
  function automatic logic upd_hit(input logic [1:0] wr,
                                   input logic [CTRL_W-1:0] lw,
                                   input logic [CTRL_W-1:0] rw);
    upd_hit = (wr[CH_LEFT] && lw[UPDATE_BIT]) ||
              (wr[CH_RIGHT] && rw[UPDATE_BIT]);
  endfunction : upd_hit

  assign upd_strobe = {2{upd_hit(i_gain_ctrl_wr, i_left_gain_ctrl,
                                 i_right_gain_ctrl)}};

  // ***********************************************************************
  // channel logic
  // ***********************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      logic auto_wr;
      logic zc_en_now;
      assign auto_wr = i_auto_level_wr[ch] && i_auto_level_control_en[ch];

      // a write carries its own zero-cross enable, so its change is gated
      // by the new setting rather than by the one it replaces
      assign zc_en_now = i_gain_ctrl_wr[ch] ? wr_word[ch][ZC_EN_BIT]
                                            : zc_en_q[ch];

      // pending gain: software word or level control; the 6-bit code
      // covers 64 codes, 0.75 dB apart, from -12 dB up to +35.25 dB
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          pend_q[ch] <= GAIN_RST;
        end else if (auto_wr) begin
          pend_q[ch] <= auto_g[ch];
        end else if (i_gain_ctrl_wr[ch]) begin
          pend_q[ch] <= wr_word[ch][GAIN_LSB +: GAIN_W];
        end
      end

      // mute and zero-cross enable are plain stored bits
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          unmute_q[ch] <= UNMUTE_RST;
          zc_en_q[ch]  <= ZC_EN_RST;
        end else if (i_gain_ctrl_wr[ch]) begin
          unmute_q[ch] <= wr_word[ch][UNMUTE_BIT];
          zc_en_q[ch]  <= wr_word[ch][ZC_EN_BIT];
        end
      end

      // level control changes are self-updating, so they request too
      igu_apply_gate u_gate (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_req        (upd_strobe[ch] || auto_wr),
        .i_zc_en      (zc_en_now),
        .i_zero_cross (i_zero_cross[ch]),
        .i_tmo_en     (i_zero_cross_timeout_ctrl),
        .i_slow_tick  (i_slow_tick),
        .o_apply      (apply[ch]),
        .o_waiting    (o_change_waiting[ch])
      );

      // on apply during a write to this channel with either channel's update bit set take the
      // incoming word; a write meeting an apply with no update strobe releases the older pending gain
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          active_q[ch] <= GAIN_RST;
        end else if (apply[ch]) begin
          if (auto_wr) begin
            active_q[ch] <= auto_g[ch];
          end else if (i_gain_ctrl_wr[ch] && upd_strobe[ch]) begin
            active_q[ch] <= wr_word[ch][GAIN_LSB +: GAIN_W];
          end else begin
            active_q[ch] <= pend_q[ch];
          end
        end
      end

      // switches: unselected mic pins rest on the bias tie-off
      assign o_mic_pos_in_sw[ch]    = sel[ch][SEL_POS_BIT];
      assign o_mic_pos_in_tie[ch]   = !sel[ch][SEL_POS_BIT];
      assign o_mic_neg_in_sw[ch]    = sel[ch][SEL_NEG_BIT];
      assign o_mic_neg_in_tie[ch]   = !sel[ch][SEL_NEG_BIT];
      assign o_line_level_in_sw[ch] = sel[ch][SEL_LINE_BIT];
      assign o_amp_path_en[ch] = i_amp_power[ch] && i_mix_boost_power[ch];
      assign o_mute[ch]        = !unmute_q[ch];
    end
  endgenerate

  // readback: the update bit always reads as zero
  assign o_left_gain_ctrl_rd  = {1'b0, zc_en_q[CH_LEFT], unmute_q[CH_LEFT],
                                 pend_q[CH_LEFT]};
  assign o_right_gain_ctrl_rd = {1'b0, zc_en_q[CH_RIGHT], unmute_q[CH_RIGHT],
                                 pend_q[CH_RIGHT]};
  assign o_left_active_gain   = active_q[CH_LEFT];
  assign o_right_active_gain  = active_q[CH_RIGHT];

  // ***********************************************************************
  // assertions
  // ***********************************************************************
  sequence s_upd_write_l;
    i_gain_ctrl_wr[CH_LEFT] && i_left_gain_ctrl[UPDATE_BIT] &&
    !i_left_gain_ctrl[ZC_EN_BIT] && !i_gain_ctrl_wr[CH_RIGHT] &&
    !(|i_auto_level_wr);
  endsequence

  property p_upd_apply;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_upd_write_l ##0 !zc_en_q[CH_RIGHT] |=> o_left_active_gain ==
      $past(i_left_gain_ctrl[5:0]) && o_right_active_gain ==
      $past(pend_q[CH_RIGHT]);
  endproperty
  upd_both_apply_a: assert property (p_upd_apply)
    else $error("update write did not apply both gains");

  pend_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      i_gain_ctrl_wr[CH_LEFT] && !i_left_gain_ctrl[UPDATE_BIT] &&
      !i_gain_ctrl_wr[CH_RIGHT] && !(|i_auto_level_wr) &&
      !o_change_waiting[CH_LEFT] |=> $stable(o_left_active_gain))
    else $error("gain changed without update");

  readback_upd_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      o_left_gain_ctrl_rd[UPDATE_BIT] == 1'b0 &&
      o_right_gain_ctrl_rd[UPDATE_BIT] == 1'b0)
    else $error("update bit read back as set");

  readback_word_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      i_gain_ctrl_wr[CH_LEFT] && !i_auto_level_wr[CH_LEFT] |=>
      o_left_gain_ctrl_rd == {1'b0, $past(i_left_gain_ctrl[7:0])})
    else $error("readback does not follow written word");

  zc_wait_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      o_change_waiting[CH_RIGHT] && zc_en_q[CH_RIGHT] &&
      !i_zero_cross[CH_RIGHT] && !i_slow_tick && !(|i_auto_level_wr) &&
      !(|i_gain_ctrl_wr) |=> $stable(o_right_active_gain))
    else $error("gain moved before zero crossing");

  zc_done_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      o_change_waiting[CH_RIGHT] && i_zero_cross[CH_RIGHT] &&
      !(|i_auto_level_wr) && !(|i_gain_ctrl_wr) |=>
      o_right_active_gain == $past(pend_q[CH_RIGHT]) &&
      !o_change_waiting[CH_RIGHT])
    else $error("zero crossing did not apply gain");

  tmo_bound_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      o_change_waiting[CH_RIGHT] && i_zero_cross_timeout_ctrl &&
      i_slow_tick && g_ch[1].u_gate.tick_cnt_q == 2'h2 && !(|i_gain_ctrl_wr)
      && !(|i_auto_level_wr) |=> !o_change_waiting[CH_RIGHT])
    else $error("timeout did not force gain");

  tie_sw_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_mic_pos_in_sw ^ o_mic_pos_in_tie) == 2'h3 &&
      (o_mic_neg_in_sw ^ o_mic_neg_in_tie) == 2'h3)
    else $error("mic pin both switched and tied");

  path_pwr_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      !i_mix_boost_power[CH_LEFT] |-> !o_amp_path_en[CH_LEFT])
    else $error("path enabled without mix/boost power");

  mute_bit_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
      i_gain_ctrl_wr[CH_RIGHT] |=> o_mute[CH_RIGHT] ==
      !$past(i_right_gain_ctrl[UNMUTE_BIT]))
    else $error("mute does not follow bit 6");

endmodule : igu_input_gain_ctrl
`default_nettype wire

// ==== test_input_gain_update_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_input_gain_update_control import igu_pkg::*;;
  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              tmo_en  = 1'b0;
  logic              tick    = 1'b0;
  logic [1:0]        wr      = 2'h0;
  logic [1:0]        alc_en  = 2'h0;
  logic [1:0]        alc_wr  = 2'h0;
  logic [1:0]        zc      = 2'h0;
  logic [1:0]        amp     = 2'h0;
  logic [1:0]        mix     = 2'h0;
  logic [2:0]        sel_l   = 3'h0;
  logic [2:0]        sel_r   = 3'h0;
  logic [CTRL_W-1:0] lw      = 9'h000;
  logic [CTRL_W-1:0] rw      = 9'h000;
  logic [GAIN_W-1:0] la_g    = 6'h00;
  logic [GAIN_W-1:0] ra_g    = 6'h00;
  logic [GAIN_W-1:0] g1, g2, g3, g4;
  logic [CTRL_W-1:0] rd_l, rd_r;
  logic [GAIN_W-1:0] act_l, act_r;
  logic [1:0]        mute, wt, psw, nsw, lsw, ptie, ntie, pen;
  int                n_mismatch = 0;
  int                n_checks   = 0;

  // ***********************************************************
  // design under test, every input driven by the bench
  // ***********************************************************
  igu_input_gain_ctrl u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_gain_ctrl_wr(wr),
    .i_left_gain_ctrl(lw), .i_right_gain_ctrl(rw),
    .i_auto_level_control_en(alc_en), .i_auto_level_wr(alc_wr),
    .i_left_auto_gain(la_g), .i_right_auto_gain(ra_g),
    .i_zero_cross(zc), .i_zero_cross_timeout_ctrl(tmo_en),
    .i_slow_tick(tick), .i_left_amp_input_select(sel_l),
    .i_right_amp_input_select(sel_r), .i_amp_power(amp),
    .i_mix_boost_power(mix), .o_left_gain_ctrl_rd(rd_l),
    .o_right_gain_ctrl_rd(rd_r), .o_left_active_gain(act_l),
    .o_right_active_gain(act_r), .o_mute(mute), .o_change_waiting(wt),
    .o_mic_pos_in_sw(psw), .o_mic_neg_in_sw(nsw),
    .o_line_level_in_sw(lsw), .o_mic_pos_in_tie(ptie),
    .o_mic_neg_in_tie(ntie), .o_amp_path_en(pen));

  // 100 ns period
  always #50 i_clock = ~i_clock;

  // ***********************************************************
  // helpers: rb, gx and sw build expectations, ag reads the active gain back
  // ***********************************************************
  function automatic logic [8:0] rb(input logic z, input logic u,
                                    input logic [5:0] g);
    return {1'b0, z, u, g}; // update bit always reads zero
  endfunction : rb

  function automatic logic [8:0] gx(input logic [5:0] g);
    return {3'h0, g};
  endfunction : gx

  function automatic logic [8:0] ag(input int c);
    return (c != 0) ? {3'h0, act_r} : {3'h0, act_l};
  endfunction : ag

  function automatic logic [8:0] sw(input int b);
    return {7'h0, sel_r[b], sel_l[b]};
  endfunction : sw

  task automatic chk(input string nm, input logic [8:0] exp,
                     input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one-cycle write strobe; returns after the taking edge has landed
  task automatic wr_gain(input int ch, input logic [8:0] w);
    if (ch == 0) lw = w;
    else rw = w;
    wr[ch] = 1'b1;
    @(negedge i_clock);
    wr = 2'h0;
    @(negedge i_clock);
  endtask : wr_gain

  // bounded wait, the apply latency after a trigger is a few cycles
  task automatic wait_gain(input int ch, input logic [5:0] g);
    repeat (4) if (ag(ch) !== gx(g)) @(negedge i_clock);
  endtask : wait_gain

  task automatic pulse_tick;
    tick = 1'b1;
    @(negedge i_clock);
    tick = 1'b0;
    repeat (3) @(negedge i_clock);
  endtask : pulse_tick

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(100 * 3000);
    n_mismatch++;
    close_out();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    void'($urandom(32'hc11c));
    g1 = {1'b1, 5'($urandom)};
    g2 = 6'($urandom);
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    chk("left rd", 9'h050, rd_l);
    chk("right rd", 9'h050, rd_r);
    chk("left gain", gx(GAIN_RST), ag(0));
    chk("mute", 9'h000, {7'h0, mute});
    // pending only, then an update on the other side applies both
    wr_gain(0, {3'b001, g1});
    chk("left rd", rb(1'b0, 1'b1, g1), rd_l);
    chk("left gain", gx(GAIN_RST), ag(0));
    wr_gain(1, {3'b101, g2});
    chk("right gain", gx(g2), ag(1));
    chk("left gain", gx(g1), ag(0));
    chk("right rd", rb(1'b0, 1'b1, g2), rd_r);
    // mute follows the cleared unmute bit
    wr_gain(0, {3'b100, g1});
    chk("mute", 9'h001, {7'h0, mute});
    chk("left rd", rb(1'b0, 1'b0, g1), rd_l);
    // both ends of the code range
    wr_gain(1, {3'b101, GAIN_MIN_CODE});
    chk("right gain", gx(GAIN_MIN_CODE), ag(1));
    wr_gain(1, {3'b101, GAIN_MAX_CODE});
    chk("right gain", gx(GAIN_MAX_CODE), ag(1));
    // zero-cross gate holds the change until a crossing arrives
    g3 = {1'b0, 5'($urandom)};
    wr_gain(1, {3'b111, g3});
    chk("waiting", 9'h002, {7'h0, wt});
    repeat (4) @(negedge i_clock);
    chk("right gain", gx(GAIN_MAX_CODE), ag(1));
    zc = 2'h2;
    @(negedge i_clock);
    zc = 2'h0;
    wait_gain(1, g3);
    chk("right gain", gx(g3), ag(1));
    // no crossing: timeout forces the change on the third tick
    tmo_en = 1'b1;
    g4 = ~g3;
    wr_gain(1, {3'b111, g4});
    pulse_tick();
    pulse_tick();
    chk("right gain", gx(g3), ag(1));
    pulse_tick();
    wait_gain(1, g4);
    chk("right gain", gx(g4), ag(1));
    chk("waiting", 9'h000, {7'h0, wt});
    // level control writer: refused while disabled, applies when on
    la_g = {1'b0, 5'($urandom)};
    alc_wr = 2'h1;
    @(negedge i_clock);
    alc_wr = 2'h0;
    repeat (3) @(negedge i_clock);
    chk("left gain", gx(g1), ag(0));
    alc_en = 2'h1; // no software gain writes on this side from here
    alc_wr = 2'h1;
    @(negedge i_clock);
    alc_wr = 2'h0;
    wait_gain(0, la_g);
    chk("left gain", gx(la_g), ag(0));
    // right level control write still waits for its zero crossing
    ra_g = {1'b0, 5'($urandom)};
    alc_en = 2'h3;
    alc_wr = 2'h2;
    @(negedge i_clock);
    alc_wr = 2'h0;
    @(negedge i_clock);
    chk("waiting", 9'h002, {7'h0, wt});
    chk("right gain", gx(g4), ag(1));
    zc = 2'h2;
    @(negedge i_clock);
    zc = 2'h0;
    wait_gain(1, ra_g);
    chk("right gain", gx(ra_g), ag(1));
    // input switches, tie-offs and path power, random settings
    repeat (8) begin
      sel_l = 3'($urandom);
      sel_r = 3'($urandom);
      amp   = 2'($urandom);
      mix   = 2'($urandom);
      #10;
      chk("pos sw", sw(0), {7'h0, psw});
      chk("pos tie", sw(0) ^ 9'h003, {7'h0, ptie});
      chk("neg sw", sw(1), {7'h0, nsw});
      chk("neg tie", sw(1) ^ 9'h003, {7'h0, ntie});
      chk("line sw", sw(2), {7'h0, lsw});
      chk("path en", {7'h0, amp & mix}, {7'h0, pen});
      @(negedge i_clock);
    end
    close_out();
  end
endmodule : test_input_gain_update_control
`default_nettype wire
